// ---- rtl/gptpg_top.sv ----
// transmit test pattern generator with its input fifo
`timescale 1ns/1ps
`include "gptpg_consts.svh"

// ==========================================================================
// fifo
module gptpg_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [CW-1:0] count_reg;
    logic in_ready_reg;
    logic out_valid_reg;

    wire push = in_valid & in_ready_reg;
    wire pop = out_valid_reg & out_ready;
    wire [CW-1:0] count_next = CW'(count_reg + CW'(push) - CW'(pop));
    wire [AW-1:0] wr_ptr_next = (wr_ptr_reg == PTR_LAST) ? '0 : AW'(wr_ptr_reg + 1'h1);
    wire [AW-1:0] rd_ptr_next = (rd_ptr_reg == PTR_LAST) ? '0 : AW'(rd_ptr_reg + 1'h1);

    assign in_ready = in_ready_reg;
    assign out_valid = out_valid_reg;
    assign out_data = mem[rd_ptr_reg];

    // storage carries no reset, only the pointers, count and flags do
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            in_ready_reg <= 1'h0;
            out_valid_reg <= 1'h0;
        end else begin
            wr_ptr_reg <= push ? wr_ptr_next : wr_ptr_reg;
            rd_ptr_reg <= pop ? rd_ptr_next : rd_ptr_reg;
            count_reg <= count_next;
            in_ready_reg <= (count_next != CNT_FULL);
            out_valid_reg <= (count_next != '0);
        end
    end
endmodule

// ==========================================================================
// top
module gptpg_top
    import gptpg_pkg::*;
#(
    parameter int FIFO_DEPTH = `GPTPG_FIFO_DEPTH
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic [4:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    input wire gptpg_quad_t NORM_SYM,
    input wire logic NORM_VALID,
    output logic NORM_READY,
    input wire logic RX_TIMING,
    input wire logic TX_READY,
    output gptpg_quad_t TX_SYM,
    output logic TX_SYM_VALID,
    output logic TX_SLAVE_TIMING,
    output logic TX_SYMBOL_CLOCK_OUT
);
    // ======================================================================
    // registers
    logic [15:0] test_ctrl_reg;
    logic clk_ctrl_reg;
    logic [15:0] rdata_reg;
    logic [2:0] mode_q_reg;
    logic [9:0] wave_cnt_reg;
    logic jit_ph_reg;
    logic [10:0] scr_reg;
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic flt_reg;
    gptpg_quad_t tx_sym_reg;
    logic tx_valid_reg;
    logic slave_reg;
    logic clk_out_reg;
    gptpg_quad_t fifo_data;
    logic fifo_valid;
    logic fifo_in_ready;

    // ======================================================================
    // decode
    wire wr_test = WR & (ADDR == `GPTPG_IDX_TEST_CTRL);
    wire wr_clk = WR & (ADDR == `GPTPG_IDX_CLK_CTRL);
    wire [2:0] mode_raw = test_ctrl_reg[`GPTPG_MODE_MSB:`GPTPG_MODE_LSB];
    wire [2:0] mode_eff = (mode_raw > `GPTPG_MODE_DIST) ? `GPTPG_MODE_NORMAL : mode_raw;
    wire is_normal = (mode_eff == `GPTPG_MODE_NORMAL);
    wire is_wave = (mode_eff == `GPTPG_MODE_WAVE);
    wire is_jit = (mode_eff == `GPTPG_MODE_JIT_M) | (mode_eff == `GPTPG_MODE_JIT_S);
    wire is_dist = (mode_eff == `GPTPG_MODE_DIST);
    wire is_slave = (mode_eff == `GPTPG_MODE_JIT_S);
    wire entry = (mode_eff != mode_q_reg);

    // ======================================================================
    // symbol timing
    // filtered level moves only when the last two stages agree
    wire flt_next = (s2_reg == s3_reg) ? s3_reg : flt_reg;
    wire rx_rise = s2_reg & s3_reg & ~flt_reg;
    // master timing every clock; slave timing on recovered edge
    wire tick = is_slave ? rx_rise : 1'h1;
    wire step = tick & TX_READY;
    wire emit = step & ~entry;

    // ======================================================================
    // pattern sources
    wire [2:0] seg = wave_cnt_reg[9:7];
    wire first = (wave_cnt_reg[6:0] == 7'h00);
    wire gptpg_sym_t wave_sym = seg[2] ? (seg[0] ? `GPTPG_SYM_M2 : `GPTPG_SYM_P2) :
        (!first ? `GPTPG_SYM_ZERO :
        seg[1] ? (seg[0] ? `GPTPG_SYM_M1 : `GPTPG_SYM_P1) :
        (seg[0] ? `GPTPG_SYM_M2 : `GPTPG_SYM_P2));
    wire gptpg_sym_t jit_sym = jit_ph_reg ? `GPTPG_SYM_M2 : `GPTPG_SYM_P2;
    wire sel_bit_low = scr_reg[0];
    wire sel_bit_mid = scr_reg[1] ^ scr_reg[4];
    wire sel_bit_high = scr_reg[2] ^ scr_reg[4];
    wire gptpg_sym_t dist_sym = sel_bit_low ?
        (sel_bit_mid ? `GPTPG_SYM_M1 : `GPTPG_SYM_P1) :
        (sel_bit_mid ? (sel_bit_high ? `GPTPG_SYM_M2 : `GPTPG_SYM_P2) : `GPTPG_SYM_ZERO);
    wire gptpg_sym_t test_sym = is_wave ? wave_sym : (is_jit ? jit_sym : dist_sym);
    // shift toward bit 10, feedback from bits 8 and 10
    wire [10:0] scr_shift = {scr_reg[9:0], scr_reg[8] ^ scr_reg[10]};

    // ======================================================================
    // next values
    // counter wraps straight into the next repetition
    wire [9:0] wave_next = entry ? `GPTPG_WAVE_RST :
        ((emit & is_wave) ? 10'(wave_cnt_reg + 10'h001) : wave_cnt_reg);
    wire jit_next = entry ? 1'h0 : ((emit & is_jit) ? ~jit_ph_reg : jit_ph_reg);
    // nonzero seed on entry; one shift per symbol
    wire [10:0] scr_next = (entry & is_dist) ? `GPTPG_SCR_SEED :
        ((emit & is_dist) ? scr_shift : scr_reg);
    // test pattern drives all pairs, normal path otherwise
    wire gptpg_quad_t sym_next = is_normal ? fifo_data : {4{test_sym}};
    wire load = emit & (~is_normal | fifo_valid);
    wire [15:0] status = {wave_cnt_reg, jit_ph_reg, fifo_in_ready, is_slave, mode_eff};
    wire [15:0] rd_mux = (ADDR == `GPTPG_IDX_TEST_CTRL) ? test_ctrl_reg :
        (ADDR == `GPTPG_IDX_CLK_CTRL) ? {15'h0000, clk_ctrl_reg} :
        (ADDR == `GPTPG_IDX_STATUS) ? status : 16'h0000;
    // symbol clock toggles on every timing tick while enabled, even when no symbol is sent
    wire clk_out_next = clk_ctrl_reg ? (tick ? ~clk_out_reg : clk_out_reg) : 1'h0;

    // ======================================================================
    // input fifo, drained once per symbol; test modes discard its words
    gptpg_fifo #(
        .WIDTH($bits(gptpg_quad_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(CLOCK),
        .rst_n(RST_N),
        .in_data(NORM_SYM),
        .in_valid(NORM_VALID),
        .in_ready(fifo_in_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(emit)
    );

    // ======================================================================
    // flops
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            test_ctrl_reg <= `GPTPG_TEST_CTRL_RST;
            clk_ctrl_reg <= `GPTPG_CLK_CTRL_RST;
            rdata_reg <= 16'h0000;
        end else begin
            test_ctrl_reg <= wr_test ? WDATA : test_ctrl_reg;
            clk_ctrl_reg <= wr_clk ? WDATA[`GPTPG_CLKEN_BIT] : clk_ctrl_reg;
            rdata_reg <= RD ? rd_mux : 16'h0000;
        end
    end

    // recovered timing pin: three stages, first one feeds only the second
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            s1_reg <= 1'h0;
            s2_reg <= 1'h0;
            s3_reg <= 1'h0;
            flt_reg <= 1'h0;
        end else begin
            s1_reg <= RX_TIMING;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            flt_reg <= flt_next;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            mode_q_reg <= `GPTPG_MODE_NORMAL;
            wave_cnt_reg <= `GPTPG_WAVE_RST;
            jit_ph_reg <= 1'h0;
            scr_reg <= `GPTPG_SCR_SEED;
        end else begin
            mode_q_reg <= mode_eff;
            wave_cnt_reg <= wave_next;
            jit_ph_reg <= jit_next;
            scr_reg <= scr_next;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            tx_sym_reg <= '0;
            tx_valid_reg <= 1'h0;
            slave_reg <= 1'h0;
            clk_out_reg <= 1'h0;
        end else begin
            tx_sym_reg <= load ? sym_next : tx_sym_reg;
            tx_valid_reg <= load;
            slave_reg <= is_slave;
            clk_out_reg <= clk_out_next;
        end
    end

    assign RDATA = rdata_reg;
    assign NORM_READY = fifo_in_ready;
    assign TX_SYM = tx_sym_reg;
    assign TX_SYM_VALID = tx_valid_reg;
    assign TX_SLAVE_TIMING = slave_reg;
    assign TX_SYMBOL_CLOCK_OUT = clk_out_reg;

    // ======================================================================
    // checks
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    chk_mode_field: assert property (
        wr_test |=> (status[2:0] == (($past(WDATA[15:13]) > 3'h4) ? 3'h0 :
            $past(WDATA[15:13]))))
        else $error("mode field not taken from bits 15..13");
    chk_reserved_normal: assert property (
        (mode_raw > 3'h4) |-> (mode_eff == 3'h0) ##1 !TX_SLAVE_TIMING)
        else $error("reserved code not treated as normal");
    chk_wave_start: assert property (
        (emit && is_wave && wave_cnt_reg == 10'h080) |=> (TX_SYM.a == 3'h6 && TX_SYM_VALID))
        else $error("second waveform segment does not open with -2");
    chk_wave_wrap: assert property (
        (emit && is_wave && wave_cnt_reg == 10'h3ff) ##1 (is_wave && !entry)
            |-> (wave_cnt_reg == 10'h000))
        else $error("waveform does not restart after last symbol");
    chk_jit_alternate: assert property (
        (load && is_jit) ##1 (load && is_jit && !entry) |=> (TX_SYM.b != $past(TX_SYM.b)))
        else $error("jitter pattern does not alternate");
    chk_master_timing: assert property (
        (TX_READY && !is_slave && !entry && (!is_normal || fifo_valid)) |=> TX_SYM_VALID)
        else $error("master timing missed a symbol");
    chk_slave_timing: assert property (
        (is_slave && !rx_rise) |=> !TX_SYM_VALID)
        else $error("slave symbol without recovered edge");
    chk_scr_shift: assert property (
        (emit && is_dist) |=> (scr_reg == {$past(scr_reg[9:0]), $past(scr_reg[8] ^ scr_reg[10])}))
        else $error("shift register feedback wrong");
    chk_scr_nonzero: assert property (
        (is_dist && !entry) |-> (scr_reg != 11'h000))
        else $error("shift register locked at zero");
    chk_all_lanes: assert property (
        (load && !is_normal) |=> (TX_SYM.a == TX_SYM.b && TX_SYM.b == TX_SYM.c
            && TX_SYM.c == TX_SYM.d))
        else $error("pairs differ in test mode");
    chk_normal_pass: assert property (
        (load && is_normal) |=> (TX_SYM == $past(fifo_data)))
        else $error("normal symbols altered");
    chk_clk_out_off: assert property (
        !clk_ctrl_reg |=> !TX_SYMBOL_CLOCK_OUT)
        else $error("symbol clock out while disabled");
    chk_clk_out_tick: assert property (
        (clk_ctrl_reg && tick) |=> (TX_SYMBOL_CLOCK_OUT != $past(TX_SYMBOL_CLOCK_OUT)))
        else $error("symbol clock out missed a tick");
    chk_rdata_idle: assert property (
        !RD |=> (RDATA == 16'h0000))
        else $error("read data not zero outside a read");
    chk_dist_seed: assert property (
        (entry && is_dist) |=> (scr_reg == 11'h001))
        else $error("shift register not seeded on entry");
    chk_scr_hold: assert property (
        (!emit && !entry) |=> $stable(scr_reg))
        else $error("shift register moved without a symbol");
    chk_dist_minus2: assert property (
        (load && is_dist && !sel_bit_low && sel_bit_mid && sel_bit_high)
            |=> (TX_SYM.a == 3'h6))
        else $error("selector 110 not mapped to -2");
    chk_wave_zero: assert property (
        (emit && is_wave && !wave_cnt_reg[9] && wave_cnt_reg[6:0] != 7'h00)
            |=> (TX_SYM.a == 3'h0 && TX_SYM_VALID))
        else $error("waveform gap symbol not zero");
    chk_wave_tail: assert property (
        (emit && is_wave && wave_cnt_reg[9])
            |=> (TX_SYM.a == ($past(wave_cnt_reg[7]) ? 3'h6 : 3'h2)))
        else $error("waveform block symbol wrong");
    chk_jit_first: assert property (
        (load && is_jit && !jit_ph_reg) |=> (TX_SYM.a == 3'h2))
        else $error("jitter phase zero not +2");
endmodule

// ---- rtl/gptpg_consts.svh ----
// constants of the transmit test pattern generator
`ifndef GPTPG_CONSTS_SVH
`define GPTPG_CONSTS_SVH
`define GPTPG_IDX_TEST_CTRL 5'h09
`define GPTPG_IDX_CLK_CTRL 5'h10
`define GPTPG_IDX_STATUS 5'h11
`define GPTPG_MODE_MSB 15
`define GPTPG_MODE_LSB 13
`define GPTPG_CLKEN_BIT 0
`define GPTPG_TEST_CTRL_RST 16'h0000
`define GPTPG_CLK_CTRL_RST 1'h0
`define GPTPG_MODE_NORMAL 3'h0
`define GPTPG_MODE_WAVE 3'h1
`define GPTPG_MODE_JIT_M 3'h2
`define GPTPG_MODE_JIT_S 3'h3
`define GPTPG_MODE_DIST 3'h4
`define GPTPG_SYM_ZERO 3'h0
`define GPTPG_SYM_P1 3'h1
`define GPTPG_SYM_P2 3'h2
`define GPTPG_SYM_M1 3'h7
`define GPTPG_SYM_M2 3'h6
`define GPTPG_SCR_SEED 11'h001
`define GPTPG_WAVE_RST 10'h000
`define GPTPG_WAVE_LAST 10'h3ff
`define GPTPG_FIFO_DEPTH 8
`endif

// ---- rtl/gptpg_pkg.sv ----
// types shared by the transmit test pattern generator
package gptpg_pkg;
    // one quinary symbol, two's complement, -2..+2
    typedef logic [2:0] gptpg_sym_t;
    // one symbol for each of the four pairs
    typedef struct packed {
        gptpg_sym_t d;
        gptpg_sym_t c;
        gptpg_sym_t b;
        gptpg_sym_t a;
    } gptpg_quad_t;
endpackage

// ---- dv/gptpg_fe_model.sv ----
// front end model: transmit ready with stalls and recovered timing pulses
`timescale 1ns/1ps

// ==========================================
// front end
module gptpg_fe_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hold_en,
    input wire logic stall_en,
    input wire logic slave_en,
    output logic tx_ready,
    output logic rx_timing
);
    logic [2:0] cnt_reg;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= 3'h0;
            tx_ready <= 1'b1;
            rx_timing <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 3'h1;
            // recovered timing, one edge in eight cycles
            rx_timing <= slave_en & cnt_reg[2];
            // stalls one cycle in four, or holds off completely
            tx_ready <= ~hold_en & ~(stall_en & (cnt_reg[1:0] == 2'h3));
        end
    end
endmodule

// ---- dv/tb_top.sv ----
// self-checking bench for the transmit test pattern generator
`timescale 1ns/1ps
`include "gptpg_consts.svh"

// ==========================================
// bench
module tb_top
    import gptpg_pkg::*;
;
    logic CLOCK = 1'b0;
    logic RST_N = 1'b0;
    logic [4:0] ADDR = 5'h00;
    logic [15:0] WDATA = 16'h0000;
    logic WR = 1'b0;
    logic RD = 1'b0;
    gptpg_quad_t NORM_SYM = '0;
    logic NORM_VALID = 1'b0;
    logic hold_en = 1'b0;
    logic stall_en = 1'b0;
    logic slave_en = 1'b0;
    logic [15:0] RDATA;
    logic NORM_READY, RX_TIMING, TX_READY, TX_SYM_VALID, TX_SLAVE_TIMING, TX_SYMBOL_CLOCK_OUT;
    gptpg_quad_t TX_SYM;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    gptpg_sym_t sy[5] = '{`GPTPG_SYM_ZERO, `GPTPG_SYM_P1, `GPTPG_SYM_P2, `GPTPG_SYM_M1,
        `GPTPG_SYM_M2};
    gptpg_sym_t dmap[8] = '{`GPTPG_SYM_ZERO, `GPTPG_SYM_P1, `GPTPG_SYM_P2, `GPTPG_SYM_M1,
        `GPTPG_SYM_ZERO, `GPTPG_SYM_P1, `GPTPG_SYM_M2, `GPTPG_SYM_M1};

    gptpg_top #(.FIFO_DEPTH(8)) dut (.CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .NORM_SYM(NORM_SYM), .NORM_VALID(NORM_VALID),
        .NORM_READY(NORM_READY), .RX_TIMING(RX_TIMING), .TX_READY(TX_READY), .TX_SYM(TX_SYM),
        .TX_SYM_VALID(TX_SYM_VALID), .TX_SLAVE_TIMING(TX_SLAVE_TIMING),
        .TX_SYMBOL_CLOCK_OUT(TX_SYMBOL_CLOCK_OUT));
    gptpg_fe_model fe (.clk(CLOCK), .rst_n(RST_N), .hold_en(hold_en), .stall_en(stall_en),
        .slave_en(slave_en), .tx_ready(TX_READY), .rx_timing(RX_TIMING));

    initial begin
        forever #10 CLOCK = ~CLOCK;
    end

    // ==========================================
    // checks and bus tasks
    task automatic finish_test();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t word got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic chk_quad(input gptpg_quad_t got, input gptpg_quad_t exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t symbols got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge CLOCK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLOCK);
        WR <= 1'b0;
    endtask
    task automatic reg_rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge CLOCK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLOCK);
        RD <= 1'b0;
        #1;
        d = RDATA;
    endtask
    // one edge more skips the entry cycle and any leftover symbol of the old mode
    task automatic set_mode(input logic [2:0] m);
        reg_wr(5'h09, {m, 13'h0000});
        @(posedge CLOCK);
    endtask
    task automatic get_sym(output gptpg_quad_t s);
        int n;
        n = 0;
        do begin
            @(posedge CLOCK);
            #1;
            n++;
        end while (TX_SYM_VALID !== 1'b1 && n < 200);
        chk_bit(TX_SYM_VALID, 1'b1);
        s = TX_SYM;
    endtask
    function automatic gptpg_quad_t mkw(input int n);
        return {sy[(n + 3) % 5], sy[(n + 2) % 5], sy[(n + 1) % 5], sy[n % 5]};
    endfunction
    function automatic gptpg_sym_t wave_exp(input int i);
        int k;
        k = i % 1024;
        if (k >= 512) return (((k - 512) / 128) % 2) ? `GPTPG_SYM_M2 : `GPTPG_SYM_P2;
        if (k % 128 != 0) return `GPTPG_SYM_ZERO;
        return sy[(k / 128 == 0) ? 2 : (k / 128 == 1) ? 4 : (k / 128 == 2) ? 1 : 3];
    endfunction

    // ==========================================
    // scenarios
    task automatic t_regs();
        logic [15:0] d;
        reg_rd(5'h09, d);
        chk16(d, `GPTPG_TEST_CTRL_RST);
        reg_rd(5'h10, d);
        chk16(d, 16'h0000);
        reg_wr(5'h09, 16'h1abc);
        reg_rd(5'h09, d);
        chk16(d, 16'h1abc);
        @(posedge CLOCK);
        #1;
        chk16(RDATA, 16'h0000);
        reg_rd(5'h05, d);
        chk16(d, 16'h0000);
        set_mode(3'h0);
    endtask
    task automatic t_fifo();
        gptpg_quad_t s;
        int n;
        n = 0;
        hold_en <= 1'b1;
        @(posedge CLOCK);
        NORM_VALID <= 1'b1;
        NORM_SYM <= mkw(0);
        for (int k = 0; k < 16; k++) begin
            @(negedge CLOCK);
            if (NORM_READY === 1'b1) n++;
            @(posedge CLOCK);
            NORM_SYM <= mkw(n);
        end
        NORM_VALID <= 1'b0;
        chk16(16'(n), 16'h0008);
        hold_en <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            get_sym(s);
            chk_quad(s, mkw(i));
        end
    endtask
    task automatic t_wave();
        gptpg_quad_t s;
        logic [15:0] d;
        stall_en <= 1'b1;
        set_mode(`GPTPG_MODE_WAVE);
        for (int i = 0; i < 1030; i++) begin
            get_sym(s);
            chk_quad(s, {4{wave_exp(i)}});
        end
        reg_rd(5'h11, d);
        chk16(d & 16'h000f, 16'h0001);
        stall_en <= 1'b0;
    endtask
    task automatic t_jit(input logic [2:0] m);
        gptpg_quad_t s;
        int t0;
        t0 = 0;
        slave_en <= (m == `GPTPG_MODE_JIT_S);
        reg_wr(5'h10, 16'h0001);
        set_mode(m);
        for (int i = 0; i < 6; i++) begin
            get_sym(s);
            chk_quad(s, {4{sy[(i % 2) ? 4 : 2]}});
            chk_bit(TX_SLAVE_TIMING, m == `GPTPG_MODE_JIT_S);
            if (i > 0) chk_bit(cycles - t0 > 4, m == `GPTPG_MODE_JIT_S);
            t0 = cycles;
        end
        if (m == `GPTPG_MODE_JIT_M) begin
            s[0] = TX_SYMBOL_CLOCK_OUT;
            @(posedge CLOCK);
            #1;
            chk_bit(TX_SYMBOL_CLOCK_OUT, ~s[0]);
        end
        reg_wr(5'h10, 16'h0000);
        repeat (2) @(posedge CLOCK);
        #1;
        chk_bit(TX_SYMBOL_CLOCK_OUT, 1'b0);
        slave_en <= 1'b0;
    endtask
    task automatic t_dist();
        gptpg_quad_t s;
        logic [10:0] r;
        logic [2:0] x;
        r = `GPTPG_SCR_SEED;
        set_mode(`GPTPG_MODE_DIST);
        for (int i = 0; i < 60; i++) begin
            get_sym(s);
            x = {r[2] ^ r[4], r[1] ^ r[4], r[0]};
            chk_quad(s, {4{dmap[x]}});
            r = {r[9:0], r[8] ^ r[10]};
        end
    endtask
    task automatic t_resv();
        gptpg_quad_t s;
        logic [15:0] d;
        for (int m = 5; m < 8; m++) begin
            set_mode(3'(m));
            reg_rd(5'h11, d);
            chk16(d & 16'h0007, 16'h0000);
            @(posedge CLOCK);
            NORM_VALID <= 1'b1;
            NORM_SYM <= mkw(m);
            @(posedge CLOCK);
            NORM_VALID <= 1'b0;
            get_sym(s);
            chk_quad(s, mkw(m));
        end
    endtask

    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 10000) begin
            error_cnt++;
            $display("[ERR] %0t run too long", $time);
            finish_test();
        end
    end

    initial begin
        repeat (8) @(posedge CLOCK);
        RST_N <= 1'b1;
        t_regs();
        t_fifo();
        t_wave();
        t_jit(`GPTPG_MODE_JIT_M);
        t_jit(`GPTPG_MODE_JIT_S);
        t_dist();
        t_resv();
        finish_test();
    end
endmodule
